/* File: shared/sccl_pkg.sv */
// Shared constants and types for the serdes channel configuration latches
package sccl_pkg;

    localparam int NUM_CHANNELS = 4;
    localparam int CHAN_W       = 2;
    localparam int DATA_W       = 8;
    localparam int CTRL_W       = 2;
    localparam int OFFSET_W     = 4;
    localparam int MULT_W       = 5;

    // Latch selector carried with a configuration write
    typedef enum logic [2:0] {
        SCCL_LATCH_TX_CLOCK_SOURCE = 3'h0,
        SCCL_LATCH_TX_PLL_RATE     = 3'h1,
        SCCL_LATCH_REFRAME         = 3'h2,
        SCCL_LATCH_RX_POWER        = 3'h3,
        SCCL_LATCH_RX_SELFTEST_N   = 3'h4,
        SCCL_LATCH_TX_SELFTEST_N   = 3'h5
    } sccl_latch_t;

    // Initialization values
    localparam logic INIT_TX_CLOCK_SOURCE = 1'h1;
    localparam logic INIT_TX_PLL_RATE     = 1'h0;
    localparam logic INIT_REFRAME         = 1'h1;
    localparam logic INIT_RX_POWER        = 1'h0;
    localparam logic INIT_RX_SELFTEST_N   = 1'h1;
    localparam logic INIT_TX_SELFTEST_N   = 1'h1;

    // Clock source and rate encodings
    localparam logic SRC_REFERENCE = 1'h1;
    localparam logic SRC_TX_INPUT  = 1'h0;
    localparam logic RATE_FULL     = 1'h0;
    localparam logic RATE_DOUBLE   = 1'h1;

    // Transmit PLL multipliers
    localparam logic [MULT_W-1:0] MULT_FULL   = 5'h0A;
    localparam logic [MULT_W-1:0] MULT_DOUBLE = 5'h14;

    localparam logic [DATA_W-1:0]   DATA_RESET   = 8'h00;
    localparam logic [CTRL_W-1:0]   CTRL_RESET   = 2'h0;
    localparam logic [OFFSET_W-1:0] OFFSET_RESET = 4'h0;

endpackage : sccl_pkg

/* File: core/sccl_latches.sv */
// Per-channel configuration latches and the transmit input capture they steer
// Overview of operation
// R1: Clock-source latch resets to 1; inputs captured on reference rising edge, phase buffer bypassed.
// R2: Clock-source latch at 0 captures inputs on the channel transmit input clock rising edge.
// R3: Rate latch resets to 0; at 0 the transmit PLL multiplies by 10.
// R4: Rate latch at 0 gives a full-rate transmit clock output following the reference.
// R5: Rate latch at 1 multiplies by 20 and doubles the transmit clock output frequency; here tx_clock_output still follows the reference at full rate.
// R6: Both latches at 1 capture transmit data on both reference clock edges.
// R7: Host must never set the rate latch while speed select is low.
// R8: Reframe latch resets to 1; framer aligns with selected mode and character.
// R9: Reframe latch at 0 disables the framer and freezes the frame offset.
// R10: Receive power latch resets to 0, powering down; writing 1 powers up.
// R11: Receive self-test latch is active low, resets to 1; writing 0 enables.
// R12: Transmit self-test latch is active low, resets to 1; writing 0 enables.
// R13: Each of the four channels holds its own independent copy of every latch.
// R14: Device reset loads every latch with its initialization value.
`timescale 1ns/1ps
module sccl_latches (
    // Clock and reset
    input  wire logic                                clock,
    input  wire logic                                srst,
    // Configuration write port
    input  wire logic                                cfg_write,
    input  wire logic [sccl_pkg::CHAN_W-1:0]         cfg_channel,
    input  wire sccl_pkg::sccl_latch_t               cfg_latch,
    input  wire logic                                cfg_value,
    // Per-channel clocks and speed select sampled as levels
    input  wire logic [sccl_pkg::NUM_CHANNELS-1:0]   channel_reference_clock,
    input  wire logic [sccl_pkg::NUM_CHANNELS-1:0]   tx_input_clock,
    input  wire logic [sccl_pkg::NUM_CHANNELS-1:0]   speed_range_select,
    // Per-channel transmit inputs
    input  wire logic [sccl_pkg::DATA_W-1:0]         tx_parallel_data    [sccl_pkg::NUM_CHANNELS],
    input  wire logic [sccl_pkg::CTRL_W-1:0]         tx_parallel_control [sccl_pkg::NUM_CHANNELS],
    // Framer alignment requests
    input  wire logic [sccl_pkg::NUM_CHANNELS-1:0]   frame_align_request,
    input  wire logic [sccl_pkg::OFFSET_W-1:0]       frame_align_offset  [sccl_pkg::NUM_CHANNELS],
    // Latch values
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        tx_clock_source_sel,
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        tx_pll_rate_sel,
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        reframe_enable,
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        rx_channel_power_enable,
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        rx_selftest_disable_n,
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        tx_selftest_disable_n,
    // Derived channel controls
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        tx_phase_buffer_bypass,
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        tx_dual_edge_capture,
    output logic [sccl_pkg::MULT_W-1:0]              tx_pll_multiplier   [sccl_pkg::NUM_CHANNELS],
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        tx_clock_output_double,
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        tx_clock_output,
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        config_reserved_combo,
    // Captured transmit input register
    output logic [sccl_pkg::DATA_W-1:0]              tx_input_data       [sccl_pkg::NUM_CHANNELS],
    output logic [sccl_pkg::CTRL_W-1:0]              tx_input_control    [sccl_pkg::NUM_CHANNELS],
    output logic [sccl_pkg::NUM_CHANNELS-1:0]        tx_input_valid,
    // Framer state
    output logic [sccl_pkg::OFFSET_W-1:0]            frame_offset        [sccl_pkg::NUM_CHANNELS]
);

    // Write strobe for one latch of one channel
    function automatic logic hit(input logic wr, input logic [sccl_pkg::CHAN_W-1:0] ch,
                                 input sccl_pkg::sccl_latch_t sel, input int unsigned idx,
                                 input sccl_pkg::sccl_latch_t want);
        hit = wr && (ch == idx[sccl_pkg::CHAN_W-1:0]) && (sel == want);
    endfunction : hit

    // Rate latch selects the doubled transmit clock
    function automatic logic is_double(input logic rate);
        is_double = (rate == sccl_pkg::RATE_DOUBLE);
    endfunction : is_double

    // Clock-source latch selects the reference clock
    function automatic logic is_ref_source(input logic src);
        is_ref_source = (src == sccl_pkg::SRC_REFERENCE);
    endfunction : is_ref_source

    genvar g;
    generate
        for (g = 0; g < sccl_pkg::NUM_CHANNELS; g++) begin : g_chan
            logic ref_prev;
            logic txin_prev;
            logic ref_rise;
            logic ref_fall;
            logic txin_rise;
            logic capture;

            // Clock-source latch of this channel
            always_ff @(posedge clock) begin
                if (srst) begin
                    tx_clock_source_sel[g] <= sccl_pkg::INIT_TX_CLOCK_SOURCE; // R1 R14
                end else begin
                    if (hit(cfg_write, cfg_channel, cfg_latch, g, sccl_pkg::SCCL_LATCH_TX_CLOCK_SOURCE)) begin // R13
                        tx_clock_source_sel[g] <= cfg_value;
                    end
                end
            end

            // Transmit rate latch of this channel
            always_ff @(posedge clock) begin
                if (srst) begin
                    tx_pll_rate_sel[g] <= sccl_pkg::INIT_TX_PLL_RATE; // R3 R14
                end else begin
                    if (hit(cfg_write, cfg_channel, cfg_latch, g, sccl_pkg::SCCL_LATCH_TX_PLL_RATE)) begin // R13
                        tx_pll_rate_sel[g] <= cfg_value;
                    end
                end
            end

            // Reframe latch of this channel
            always_ff @(posedge clock) begin
                if (srst) begin
                    reframe_enable[g] <= sccl_pkg::INIT_REFRAME; // R8 R14
                end else begin
                    if (hit(cfg_write, cfg_channel, cfg_latch, g, sccl_pkg::SCCL_LATCH_REFRAME)) begin // R13
                        reframe_enable[g] <= cfg_value;
                    end
                end
            end

            // Receive power latch of this channel
            always_ff @(posedge clock) begin
                if (srst) begin
                    rx_channel_power_enable[g] <= sccl_pkg::INIT_RX_POWER; // R10 R14
                end else begin
                    if (hit(cfg_write, cfg_channel, cfg_latch, g, sccl_pkg::SCCL_LATCH_RX_POWER)) begin // R13
                        rx_channel_power_enable[g] <= cfg_value; // R10
                    end
                end
            end

            // Receive self-test latch of this channel
            always_ff @(posedge clock) begin
                if (srst) begin
                    rx_selftest_disable_n[g] <= sccl_pkg::INIT_RX_SELFTEST_N; // R11 R14
                end else begin
                    if (hit(cfg_write, cfg_channel, cfg_latch, g, sccl_pkg::SCCL_LATCH_RX_SELFTEST_N)) begin // R13
                        rx_selftest_disable_n[g] <= cfg_value; // R11
                    end
                end
            end

            // Transmit self-test latch of this channel
            always_ff @(posedge clock) begin
                if (srst) begin
                    tx_selftest_disable_n[g] <= sccl_pkg::INIT_TX_SELFTEST_N; // R12 R14
                end else begin
                    if (hit(cfg_write, cfg_channel, cfg_latch, g, sccl_pkg::SCCL_LATCH_TX_SELFTEST_N)) begin // R13
                        tx_selftest_disable_n[g] <= cfg_value; // R12
                    end
                end
            end

            // Edge detection on sampled clocks
            always_ff @(posedge clock) begin
                if (srst) begin
                    // Track levels through reset so release shows no false edge
                    ref_prev  <= channel_reference_clock[g];
                    txin_prev <= tx_input_clock[g];
                end else begin
                    ref_prev  <= channel_reference_clock[g];
                    txin_prev <= tx_input_clock[g];
                end
            end

            assign ref_rise  = channel_reference_clock[g] & ~ref_prev;
            assign ref_fall  = ~channel_reference_clock[g] & ref_prev;
            assign txin_rise = tx_input_clock[g] & ~txin_prev;

            // Capture source selection
            always_comb begin
                if (is_ref_source(tx_clock_source_sel[g])) begin
                    capture = ref_rise; // R1
                    if (is_double(tx_pll_rate_sel[g])) begin
                        capture = ref_rise | ref_fall; // R6
                    end
                end else begin
                    capture = txin_rise; // R2
                end
            end

            // Transmit input register
            always_ff @(posedge clock) begin
                if (srst) begin
                    tx_input_data[g]    <= sccl_pkg::DATA_RESET;
                    tx_input_control[g] <= sccl_pkg::CTRL_RESET;
                    tx_input_valid[g]   <= 1'h0;
                end else begin
                    tx_input_valid[g] <= capture;
                    if (capture) begin
                        tx_input_data[g]    <= tx_parallel_data[g];
                        tx_input_control[g] <= tx_parallel_control[g];
                    end
                end
            end

            // Transmit clock output follows the reference in full-rate mode
            always_ff @(posedge clock) begin
                if (srst) begin
                    tx_clock_output[g] <= 1'h0;
                end else begin
                    tx_clock_output[g] <= channel_reference_clock[g]; // R4
                end
            end

            // Derived PLL and buffer controls
            always_ff @(posedge clock) begin
                if (srst) begin
                    tx_phase_buffer_bypass[g] <= sccl_pkg::INIT_TX_CLOCK_SOURCE;
                    tx_dual_edge_capture[g]   <= 1'h0;
                    tx_pll_multiplier[g]      <= sccl_pkg::MULT_FULL;
                    tx_clock_output_double[g] <= 1'h0;
                    config_reserved_combo[g]  <= 1'h0;
                end else begin
                    tx_phase_buffer_bypass[g] <= is_ref_source(tx_clock_source_sel[g]); // R1
                    tx_dual_edge_capture[g]   <= is_ref_source(tx_clock_source_sel[g])
                                                 && is_double(tx_pll_rate_sel[g]); // R6
                    tx_pll_multiplier[g]      <= is_double(tx_pll_rate_sel[g])
                                                 ? sccl_pkg::MULT_DOUBLE : sccl_pkg::MULT_FULL; // R3 R5
                    tx_clock_output_double[g] <= is_double(tx_pll_rate_sel[g]); // R5
                    config_reserved_combo[g]  <= tx_pll_rate_sel[g] & ~speed_range_select[g]; // R7
                end
            end

            // Framer offset, frozen while reframing is disabled
            always_ff @(posedge clock) begin
                if (srst) begin
                    frame_offset[g] <= sccl_pkg::OFFSET_RESET;
                end else if (reframe_enable[g] && frame_align_request[g]) begin // R8 R9
                    frame_offset[g] <= frame_align_offset[g];
                end
            end
        end
    endgenerate

endmodule : sccl_latches

/* File: tb/sccl_host_model.sv */
// Host controller model that writes the configuration latches
`timescale 1ns/1ps
module sccl_host_model (
    // Clock and speed select seen by the host
    input  wire logic        clock,
    input  wire logic [3:0]  speed_range_select,
    // Configuration write port
    output logic             cfg_write,
    output logic [1:0]       cfg_channel,
    output sccl_pkg::sccl_latch_t cfg_latch,
    output logic             cfg_value
);
    initial begin
        cfg_write = 1'b0;
        cfg_channel = 2'h0;
        cfg_latch = sccl_pkg::SCCL_LATCH_TX_CLOCK_SOURCE;
        cfg_value = 1'b0;
    end
    // One-cycle strobe from falling edge to falling edge
    task automatic write_latch(input logic [1:0] ch, input logic [2:0] sel, input logic val);
        @(negedge clock);
        if (sel == 3'h1 && val && !speed_range_select[ch]) begin
            return;
        end
        cfg_write <= 1'b1;
        cfg_channel <= ch;
        cfg_latch <= sccl_pkg::sccl_latch_t'(sel);
        cfg_value <= val;
        @(negedge clock);
        cfg_write <= 1'b0;
        cfg_channel <= ~ch;
        cfg_value <= ~val;
    endtask : write_latch
endmodule : sccl_host_model

/* File: tb/sccl_latches_chk.sv */
// Assertion checker for the channel configuration latches
`timescale 1ns/1ps
module sccl_latches_chk (
    // Clock, reset and write port
    input wire logic        clock, srst, cfg_write, cfg_value,
    input wire logic [1:0]  cfg_channel,
    input wire sccl_pkg::sccl_latch_t cfg_latch,
    input wire logic [3:0]  channel_reference_clock,
    // Latches and derived controls
    input wire logic [3:0]  tx_clock_source_sel, tx_pll_rate_sel, reframe_enable, rx_channel_power_enable,
    input wire logic [3:0]  rx_selftest_disable_n, tx_selftest_disable_n, tx_phase_buffer_bypass,
    input wire logic [3:0]  tx_dual_edge_capture, tx_clock_output_double, tx_clock_output,
    input wire logic [4:0]  tx_pll_multiplier [4]
);
    wire logic [23:0] latches = {tx_clock_source_sel, tx_pll_rate_sel, reframe_enable,
                                 rx_channel_power_enable, rx_selftest_disable_n, tx_selftest_disable_n};
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    init_vals_a: assert property (disable iff (1'b0) srst |=> latches == 24'hF0_F0FF)
        else $error("latches not at initial values");
    write_take_a: assert property (cfg_write && cfg_latch < 3'h6 |=>
        latches[(5 - $past(cfg_latch)) * 4 + $past(cfg_channel)] == $past(cfg_value)) else $error("write lost");
    latch_hold_a: assert property (!(cfg_write && cfg_latch < 3'h6) |=> $stable(latches))
        else $error("latch changed without write");
    buffer_bypass_a: assert property (tx_phase_buffer_bypass == $past(tx_clock_source_sel))
        else $error("bypass does not follow clock source");
    dual_edge_a: assert property (tx_dual_edge_capture == $past(tx_clock_source_sel & tx_pll_rate_sel))
        else $error("dual edge capture wrong");
    pll_mult_a: assert property (tx_pll_multiplier[2] ==
        ($past(tx_pll_rate_sel[2]) ? sccl_pkg::MULT_DOUBLE : sccl_pkg::MULT_FULL)) else $error("multiplier wrong");
    clock_double_a: assert property (tx_clock_output_double == $past(tx_pll_rate_sel))
        else $error("double rate flag wrong");
    clock_follow_a: assert property (!$past(srst) |-> tx_clock_output == $past(channel_reference_clock))
        else $error("clock output does not follow reference");
endmodule : sccl_latches_chk

bind sccl_latches sccl_latches_chk u_chk (.*);

/* File: tb/sccl_latches_tb_top.sv */
// Testbench for the channel configuration latches
`timescale 1ns/1ps
module sccl_latches_tb_top;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cfg_write, cfg_value;
    logic [1:0] cfg_channel;
    sccl_pkg::sccl_latch_t cfg_latch;
    logic [3:0] channel_reference_clock = '0, tx_input_clock = '0, speed_range_select = 4'hF, frame_align_request = '0;
    logic [7:0] tx_parallel_data [4] = '{default: 8'h00};
    logic [1:0] tx_parallel_control [4] = '{default: 2'h0};
    logic [3:0] frame_align_offset [4] = '{default: 4'h0};
    logic [7:0] tx_input_data [4];
    logic [1:0] tx_input_control [4];
    logic [3:0] frame_offset [4];
    logic [3:0] tx_clock_source_sel, tx_pll_rate_sel, reframe_enable, rx_channel_power_enable, rx_selftest_disable_n;
    logic [3:0] tx_selftest_disable_n, tx_phase_buffer_bypass, tx_dual_edge_capture, tx_clock_output_double;
    logic [3:0] tx_clock_output, tx_input_valid, config_reserved_combo;
    logic [4:0] tx_pll_multiplier [4];
    logic [23:0] exp_lat;
    int bad_count = 0;
    int n_checks = 0;
    wire logic [23:0] lat = {tx_clock_source_sel, tx_pll_rate_sel, reframe_enable,
                             rx_channel_power_enable, rx_selftest_disable_n, tx_selftest_disable_n};
    always #2 clock = ~clock;
    sccl_host_model u_host (.*);
    sccl_latches u_dut (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step
    task automatic close_out();
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    initial begin
        step(6);
        srst = 1'b0;
        check(lat, 24'hF0_F0FF);
        check(tx_pll_multiplier[0], sccl_pkg::MULT_FULL);
        exp_lat = 24'hF0_F0FF;
        for (int l = 0; l < 6; l++) begin
            u_host.write_latch(2'h2, 3'(l), ~exp_lat[(5 - l) * 4 + 2]);
            exp_lat[(5 - l) * 4 + 2] = ~exp_lat[(5 - l) * 4 + 2];
        end
        step(1);
        check(lat, exp_lat);
        check(tx_pll_multiplier[2], sccl_pkg::MULT_DOUBLE);
        check(tx_clock_output_double, 4'h4);
        u_host.write_latch(2'h2, 3'h0, 1'b1);
        u_host.write_latch(2'h0, 3'h6, 1'b0);
        step(1);
        exp_lat[22] = 1'b1;
        check(lat, exp_lat);
        check(tx_dual_edge_capture, 4'h4);
        tx_parallel_data[0] = 8'hA5;
        channel_reference_clock[0] = 1'b1;
        step(1);
        check(tx_input_valid, 4'h1);
        step(1);
        check(tx_input_data[0], 8'hA5);
        tx_parallel_data[0] = 8'h5A;
        channel_reference_clock[0] = 1'b0;
        step(2);
        check(tx_input_data[0], 8'hA5);
        u_host.write_latch(2'h1, 3'h0, 1'b0);
        tx_parallel_data[1] = 8'h11;
        channel_reference_clock[1] = 1'b1;
        step(2);
        check(tx_input_data[1], 8'h00);
        tx_parallel_data[1] = 8'h3C;
        tx_parallel_control[1] = 2'h3;
        tx_input_clock[1] = 1'b1;
        step(2);
        check({tx_input_control[1], tx_input_data[1]}, 10'h33C);
        tx_parallel_data[2] = 8'h77;
        channel_reference_clock[2] = 1'b1;
        step(2);
        tx_parallel_data[2] = 8'h88;
        channel_reference_clock[2] = 1'b0;
        step(1);
        check(tx_input_valid, 4'h4);
        step(1);
        check(tx_input_data[2], 8'h88);
        frame_align_offset[3] = 4'h5;
        frame_align_request[3] = 1'b1;
        step(2);
        check(frame_offset[3], 4'h5);
        frame_align_request[3] = 1'b0;
        u_host.write_latch(2'h3, 3'h2, 1'b0);
        frame_align_offset[3] = 4'h9;
        frame_align_request[3] = 1'b1;
        step(2);
        check(frame_offset[3], 4'h5);
        frame_align_request[3] = 1'b0;
        speed_range_select = 4'hA;
        u_host.write_latch(2'h0, 3'h1, 1'b1);
        step(1);
        check(tx_pll_rate_sel, 4'h4);
        check(config_reserved_combo, 4'h4);
        speed_range_select = 4'hF;
        srst = 1'b1;
        step(2);
        srst = 1'b0;
        check(lat, 24'hF0_F0FF);
        check(tx_pll_multiplier[2], sccl_pkg::MULT_FULL);
        check(frame_offset[3], 4'h0);
        close_out();
    end
    initial begin
        #4000;
        bad_count++;
        close_out();
    end
endmodule : sccl_latches_tb_top
